// ---- src/cms_defs.svh ----
/*
 * constants of the can mode and status block: register offsets,
 * field positions, reset values and bit counts.
 * assumes: included by its bare name from the design file.
 */
`ifndef CMS_DEFS_SVH
`define CMS_DEFS_SVH

// ---------------------------------------------------------------
// register byte addresses
// ---------------------------------------------------------------
`define CMS_OFF_MCR        4'h0
`define CMS_OFF_MSR        4'h4
`define CMS_OFF_TSR        4'h8
`define CMS_OFF_RXF        4'hC

// ---------------------------------------------------------------
// master control fields
// ---------------------------------------------------------------
`define CMS_MCR_INIT       0
`define CMS_MCR_SLEEP      1
`define CMS_MCR_TXORD      2
`define CMS_MCR_LOCK       3
`define CMS_MCR_SSHOT      4
`define CMS_MCR_AWAKE      5
`define CMS_MCR_ABOFF      6
`define CMS_MCR_RST        8'h02
`define CMS_MCR_MASK       8'h7F

// ---------------------------------------------------------------
// master status fields
// ---------------------------------------------------------------
`define CMS_MSR_INIT_ACK       0
`define CMS_MSR_SLEEP_ACK       1
`define CMS_MSR_ERROR_EVENT_FLAG       2
`define CMS_MSR_WAKEUP_FLAG       3
`define CMS_MSR_TRAN       4
`define CMS_MSR_RXACT      5
`define CMS_MSR_RST        8'h02

// ---------------------------------------------------------------
// transmit status fields
// ---------------------------------------------------------------
`define CMS_TSR_RQ0        0
`define CMS_TSR_OK0        4
`define CMS_TSR_RST        8'h00

// ---------------------------------------------------------------
// receive fifo / release register fields
// ---------------------------------------------------------------
`define CMS_RXF_RELEASE    5

// ---------------------------------------------------------------
// bus timing counts and receive fifo depth
// ---------------------------------------------------------------
`define CMS_RECESSIVE_RUN  11
`define CMS_BUSOFF_SEQS    128
`define CMS_FIFO_DEPTH     3

`endif

// ---- src/cms_pkg.sv ----
/*
 * types of the can mode and status block.
 * assumes: nothing beyond a systemverilog compiler.
 */
package cms_pkg;
    // controller operating modes
    typedef enum logic [2:0] {
        CMS_INIT,
        CMS_SYNC,
        CMS_NORMAL,
        CMS_SLEEP,
        CMS_BUSOFF
    } cms_mode_e;
endpackage : cms_pkg

// ---- src/cms_can_mode_status.sv ----
/*
 * mode control and status registers of a can controller: init and
 * sleep handshakes, bus-off recovery, wake-up, tx/rx policy outputs,
 * event flags and per-mailbox completion flags, on classic wishbone.
 * assumes: CAN_RX and BIT_TICK synchronous to REF_CLK; the protocol
 * engine reports frames, errors and mailbox completions as pulses.
 */
// Chosen here: the Wishbone slave port and the placing of the registers.
`timescale 1ns/1ps
`include "cms_defs.svh"

module cms_can_mode_status (
    input  wire logic       REF_CLK,      // 25 mhz system clock
    input  wire logic       RESETN,       // synchronous, active low
    input  wire logic [3:0] WB_ADR_I,     // byte address
    input  wire logic [7:0] WB_DAT_I,     // write data
    output logic      [7:0] WB_DAT_O,     // read data
    input  wire logic       WB_WE_I,      // write enable
    input  wire logic       WB_SEL_I,     // byte select
    input  wire logic       WB_STB_I,     // strobe
    input  wire logic       WB_CYC_I,     // cycle
    output logic            WB_ACK_O,     // acknowledge
    input  wire logic       CAN_RX,       // bus receive line
    input  wire logic       BIT_TICK,     // one pulse per bit time
    input  wire logic       FRAME_BUSY,   // frame on the bus
    input  wire logic       RX_ROLE,      // engine is receiver
    input  wire logic       TX_ROLE,      // engine is transmitter
    input  wire logic       SOF_SEEN,     // start of frame pulse
    input  wire logic       BUSOFF_ENTER, // bus-off entry pulse
    input  wire logic [3:0] ERR_SET,      // error status bits set
    input  wire logic [3:0] ERR_IRQ_EN,   // their individual enables
    input  wire logic       ERROR_IRQ_ENABLE, // error irq enable
    input  wire logic       WAKEUP_IRQ_ENABLE, // wake irq enable
    input  wire logic       MSG_STORED,   // filtered message arrived
    input  wire logic [1:0] TX_REQUEST,   // mailbox requested
    input  wire logic [1:0] TX_DONE_OK,   // mailbox sent fine
    input  wire logic [1:0] TX_DONE_ANY,  // transmit/abort finished
    output logic            CAN_ACTIVE,   // normal mode, may use bus
    output logic            SINGLE_SHOT_TX,
    output logic            TX_ORDER_BY_REQUEST,
    output logic            RETRY_ALLOWED,   // resend after failure
    output logic            FIFO_WRITE,      // store arriving message
    output logic            FIFO_OVERWRITE,  // replace newest slot
    output logic [1:0]      RX_PENDING_COUNT,
    output logic            STATUS_IRQ       // status-change interrupt
);

    // -----------------------------------------------------------
    // state
    // -----------------------------------------------------------
    cms_pkg::cms_mode_e mode;          // operating mode
    logic [6:0]  ctrl;                 // master control bits 6:0
    logic        wakeup_flag;          // sticky wake event
    logic        error_event_flag;     // sticky error event
    logic [1:0]  tx_success;           // per mailbox success
    logic [1:0]  request_done;         // per mailbox completion
    logic [3:0]  rec_run;              // recessive bit run length
    logic [7:0]  seq_cnt;              // bus-off recovery runs
    logic [1:0]  pending;              // messages in fifo

    logic        bus_wr;               // write accepted this cycle
    logic        bus_req;              // request presented
    logic        run_done;             // eleven recessive bits seen
    logic        wake_auto;            // automatic wake event
    logic [7:0]  wdat;                 // write data, taken straight from WB_DAT_I
    logic        release_req;          // fifo output release

    // -----------------------------------------------------------
    // address decode helper
    // -----------------------------------------------------------
    function automatic logic hit(input logic [3:0] off);
        hit = bus_wr && (WB_ADR_I == off);
    endfunction : hit

    assign bus_req  = WB_CYC_I && WB_STB_I;
    // a write lands at the edge that sees ack high, while the
    // master still holds the request, never at the taking edge
    assign bus_wr   = bus_req && WB_WE_I && WB_SEL_I && WB_ACK_O;
    assign wdat     = WB_DAT_I;
    assign run_done = BIT_TICK && CAN_RX &&
                      (rec_run == 4'(`CMS_RECESSIVE_RUN - 1));
    // sof wakes only with auto wake set
    assign wake_auto = (mode == cms_pkg::CMS_SLEEP) && SOF_SEEN &&
                       ctrl[`CMS_MCR_AWAKE];
    assign release_req = hit(`CMS_OFF_RXF) &&
                         wdat[`CMS_RXF_RELEASE] && (pending != 2'h0);

    // -----------------------------------------------------------
    // wishbone acknowledge, one wait state
    // -----------------------------------------------------------
    // ack rises one cycle after a request is taken
    always_ff @(posedge REF_CLK) begin
        if (!RESETN) begin
            WB_ACK_O <= 1'b0;
        end else begin
            WB_ACK_O <= bus_req && !WB_ACK_O;
        end
    end

    // -----------------------------------------------------------
    // read data mux, registered
    // -----------------------------------------------------------
    always_ff @(posedge REF_CLK) begin
        if (!RESETN) begin
            WB_DAT_O <= 8'h00;
        end else if (bus_req && !WB_ACK_O) begin
            case (WB_ADR_I)
                `CMS_OFF_MCR: WB_DAT_O <= {1'b0, ctrl};
                // role flags and status, reserved zero
                `CMS_OFF_MSR: WB_DAT_O <= {2'b00, RX_ROLE, TX_ROLE,
                                    wakeup_flag, error_event_flag,
                                    mode == cms_pkg::CMS_SLEEP,
                                    (mode == cms_pkg::CMS_INIT) ||
                                    (mode == cms_pkg::CMS_SYNC)};
                `CMS_OFF_TSR: WB_DAT_O <= {2'b00, tx_success,
                                           2'b00, request_done};
                `CMS_OFF_RXF: WB_DAT_O <= {6'h00, pending};
                default:      WB_DAT_O <= 8'h00;   // unmapped reads 0
            endcase
        end
    end

    // -----------------------------------------------------------
    // master control register
    // -----------------------------------------------------------
    always_ff @(posedge REF_CLK) begin
        if (!RESETN) begin
            ctrl <= 7'(`CMS_MCR_RST);
        end else begin
            if (hit(`CMS_OFF_MCR)) begin
                ctrl <= wdat[6:0];
            end
            if (wake_auto) begin
                ctrl[`CMS_MCR_SLEEP] <= 1'b0;
            end
        end
    end

    // -----------------------------------------------------------
    // recessive run counter, counts bit times of high rx
    // -----------------------------------------------------------
    always_ff @(posedge REF_CLK) begin
        if (!RESETN) begin
            rec_run <= 4'h0;
        end else if (BIT_TICK) begin
            if (!CAN_RX || run_done) begin
                rec_run <= 4'h0;             // dominant or run complete
            end else begin
                rec_run <= rec_run + 4'h1;
            end
        end
    end

    // -----------------------------------------------------------
    // mode sequencer
    // -----------------------------------------------------------
    always_ff @(posedge REF_CLK) begin
        if (!RESETN) begin
            // parks asleep: status 02h, control 02h
            mode    <= cms_pkg::CMS_SLEEP;
            seq_cnt <= 8'h00;
        end else begin
            case (mode)
                cms_pkg::CMS_INIT: begin
                    if (!ctrl[`CMS_MCR_INIT]) begin
                        mode <= cms_pkg::CMS_SYNC;
                    end
                end
                cms_pkg::CMS_SYNC: begin
                    if (ctrl[`CMS_MCR_INIT]) begin
                        mode <= cms_pkg::CMS_INIT;
                    end else if (run_done) begin
                        mode <= cms_pkg::CMS_NORMAL;
                    end
                end
                cms_pkg::CMS_NORMAL: begin
                    if (BUSOFF_ENTER) begin
                        mode    <= cms_pkg::CMS_BUSOFF;
                        seq_cnt <= 8'h00;
                    end else if (ctrl[`CMS_MCR_INIT] && !FRAME_BUSY) begin
                        mode <= cms_pkg::CMS_INIT;
                    end else if (ctrl[`CMS_MCR_SLEEP] && !FRAME_BUSY) begin
                        mode <= cms_pkg::CMS_SLEEP;
                    end
                end
                cms_pkg::CMS_SLEEP: begin
                    if (wake_auto) begin
                        mode <= cms_pkg::CMS_NORMAL;
                    end else if (ctrl[`CMS_MCR_INIT]) begin
                        mode <= cms_pkg::CMS_INIT;
                    end else if (!ctrl[`CMS_MCR_SLEEP]) begin
                        mode <= cms_pkg::CMS_NORMAL;
                    end
                end
                cms_pkg::CMS_BUSOFF: begin
                    if (ctrl[`CMS_MCR_INIT]) begin
                        mode <= cms_pkg::CMS_INIT;
                    end else if (ctrl[`CMS_MCR_ABOFF] && run_done) begin
                        if (seq_cnt == 8'(`CMS_BUSOFF_SEQS - 1)) begin
                            mode <= cms_pkg::CMS_NORMAL;
                        end
                        seq_cnt <= seq_cnt + 8'h01;
                    end
                end
                default: mode <= cms_pkg::CMS_INIT;
            endcase
        end
    end

    // -----------------------------------------------------------
    // master status event flags
    // -----------------------------------------------------------
    always_ff @(posedge REF_CLK) begin
        if (!RESETN) begin
            wakeup_flag      <= 1'b0;
            error_event_flag <= 1'b0;
        end else begin
            if (hit(`CMS_OFF_MSR) && wdat[`CMS_MSR_WAKEUP_FLAG]) begin
                wakeup_flag <= 1'b0;
            end
            if (hit(`CMS_OFF_MSR) && wdat[`CMS_MSR_ERROR_EVENT_FLAG]) begin
                error_event_flag <= 1'b0;
            end
            if ((mode == cms_pkg::CMS_SLEEP) && SOF_SEEN) begin
                wakeup_flag <= 1'b1;
            end
            if (|(ERR_SET & ERR_IRQ_EN)) begin
                error_event_flag <= 1'b1;
            end
        end
    end

    // -----------------------------------------------------------
    // transmit status flags, one slice per mailbox
    // -----------------------------------------------------------
    for (genvar m = 0; m < 2; m++) begin : g_mb
        always_ff @(posedge REF_CLK) begin
            if (!RESETN) begin
                tx_success[m]   <= 1'b0;
                request_done[m] <= 1'b0;
            end else begin
                if (hit(`CMS_OFF_TSR) && wdat[`CMS_TSR_RQ0 + m]) begin
                    request_done[m] <= 1'b0;
                end
                if (TX_REQUEST[m] ||
                    (hit(`CMS_OFF_TSR) && wdat[`CMS_TSR_RQ0 + m])) begin
                    tx_success[m] <= 1'b0;
                end
                // set on finish, wins over clear
                if (TX_DONE_ANY[m] || TX_DONE_OK[m]) begin
                    request_done[m] <= 1'b1;
                end
                if (TX_DONE_OK[m]) begin
                    tx_success[m] <= 1'b1;
                end
            end
        end
    end

    // -----------------------------------------------------------
    // receive fifo pending count
    // -----------------------------------------------------------
    always_ff @(posedge REF_CLK) begin
        if (!RESETN) begin
            pending <= 2'h0;
        // up on store, down on release
        end else if (FIFO_WRITE && !FIFO_OVERWRITE && !release_req) begin
            pending <= pending + 2'h1;
        end else if (release_req && !(FIFO_WRITE && !FIFO_OVERWRITE)) begin
            pending <= pending - 2'h1;
        end
    end

    // -----------------------------------------------------------
    // policy outputs to the protocol engine
    // -----------------------------------------------------------
    assign CAN_ACTIVE          = (mode == cms_pkg::CMS_NORMAL);
    assign SINGLE_SHOT_TX      = ctrl[`CMS_MCR_SSHOT];
    assign RETRY_ALLOWED       = !ctrl[`CMS_MCR_SSHOT];
    assign TX_ORDER_BY_REQUEST = ctrl[`CMS_MCR_TXORD];
    // locked full fifo drops new message
    assign FIFO_WRITE = MSG_STORED &&
        !(ctrl[`CMS_MCR_LOCK] && (pending == 2'(`CMS_FIFO_DEPTH)));
    assign FIFO_OVERWRITE = FIFO_WRITE &&
        (pending == 2'(`CMS_FIFO_DEPTH));
    assign RX_PENDING_COUNT    = pending;

    assign STATUS_IRQ = (wakeup_flag && WAKEUP_IRQ_ENABLE) ||
                        (error_event_flag && ERROR_IRQ_ENABLE);

endmodule : cms_can_mode_status

// ---- verification/cms_sva.sv ----
/*
 * port assertions of the can mode and status block.
 * assumes: bound into the block from the bench top file.
 */
`timescale 1ns/1ps
module cms_sva (
    input wire logic       REF_CLK,
    input wire logic       RESETN,
    input wire logic [3:0] WB_ADR_I,
    input wire logic [7:0] WB_DAT_I,
    input wire logic [7:0] WB_DAT_O,
    input wire logic       WB_WE_I,
    input wire logic       WB_STB_I,
    input wire logic       WB_CYC_I,
    input wire logic       WB_ACK_O,
    input wire logic       FRAME_BUSY,
    input wire logic       BUSOFF_ENTER,
    input wire logic       MSG_STORED,
    input wire logic       CAN_ACTIVE,
    input wire logic       SINGLE_SHOT_TX,
    input wire logic       TX_ORDER_BY_REQUEST,
    input wire logic       RETRY_ALLOWED,
    input wire logic       FIFO_WRITE,
    input wire logic       FIFO_OVERWRITE,
    input wire logic [1:0] RX_PENDING_COUNT
);
    // ------------------------------------------------------------
    // helper logic
    // ------------------------------------------------------------
    logic       take;   // request taken at this edge
    logic       rel_wr; // fifo release written
    logic [7:0] policy; // software copy of control
    assign take   = WB_CYC_I & WB_STB_I & ~WB_ACK_O;
    // writes land at the edge that samples ack high
    assign rel_wr = WB_CYC_I & WB_STB_I & WB_ACK_O & WB_WE_I
                    & (WB_ADR_I == 4'hC);
    // control bits that only software changes
    always_ff @(posedge REF_CLK) begin
        if (!RESETN) begin
            policy <= 8'h02;
        end else if (WB_CYC_I && WB_STB_I && WB_ACK_O && WB_WE_I
                     && WB_ADR_I == 4'h0) begin
            policy <= WB_DAT_I;
        end
    end
    default clocking cb @(posedge REF_CLK);
    endclocking
    default disable iff (!RESETN);
    // ------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------
    AST_ACK_ONE_WAIT:
        assert property (take |=> WB_ACK_O ##1 !WB_ACK_O)
        else $error("ack not one cycle pulse after request");
    AST_UNMAPPED_ZERO:
        assert property (take && !WB_WE_I && WB_ADR_I[1:0] != 2'b00
                         |=> WB_DAT_O == 8'h00)
        else $error("unmapped read not zero");
    AST_POLICY:
        assert property (SINGLE_SHOT_TX == policy[4] && RETRY_ALLOWED
            != policy[4] && TX_ORDER_BY_REQUEST == policy[2])
        else $error("policy outputs differ from control");
    AST_FIFO_STORE:
        assert property (MSG_STORED && RX_PENDING_COUNT != 2'd3
                         |-> FIFO_WRITE && !FIFO_OVERWRITE)
        else $error("message not stored with room");
    AST_FIFO_COUNT:
        assert property (MSG_STORED && RX_PENDING_COUNT != 2'd3 && !rel_wr
            |=> RX_PENDING_COUNT == $past(RX_PENDING_COUNT) + 2'd1)
        else $error("pending count did not rise");
    AST_FIFO_OVERWRITE:
        assert property (MSG_STORED && RX_PENDING_COUNT == 2'd3
                         && !policy[3] |-> FIFO_OVERWRITE)
        else $error("full unlocked fifo not overwritten");
    AST_FIFO_LOCKED:
        assert property (MSG_STORED && RX_PENDING_COUNT == 2'd3
                         && policy[3] |-> !FIFO_WRITE && !FIFO_OVERWRITE)
        else $error("full locked fifo took a message");
    AST_BUSOFF_HOLD:
        assert property (BUSOFF_ENTER |=> !CAN_ACTIVE [*8])
        else $error("bus-off left at once");
    AST_FRAME_HOLD:
        assert property (CAN_ACTIVE && FRAME_BUSY && !BUSOFF_ENTER
                         |=> CAN_ACTIVE)
        else $error("normal mode left inside a frame");
endmodule : cms_sva

// ---- verification/cms_bus_model.sv ----
/*
 * can bus side model: bit ticks and the receive line.
 * assumes: shares the clock of the block.
 */
`timescale 1ns/1ps
module cms_bus_model (
    input  wire logic REF_CLK,
    input  wire logic RESETN,
    input  wire logic quiet,    // 1: bus idle, recessive
    output logic      can_rx,   // 1 = recessive
    output logic      bit_tick  // one pulse per bit time
);
    // ------------------------------------------------------------
    // bit clock, one bit every second cycle
    // ------------------------------------------------------------
    always_ff @(posedge REF_CLK) begin
        bit_tick <= RESETN & ~bit_tick;
    end
    // traffic alternates levels, so no recessive run builds up
    always_ff @(posedge REF_CLK) begin
        if (!RESETN || quiet) begin
            can_rx <= 1'b1;
        end else if (bit_tick) begin
            can_rx <= ~can_rx;
        end
    end
endmodule : cms_bus_model

// ---- verification/tb_top.sv ----
/*
 * self-checking bench of the can mode and status block.
 * assumes: design, checker and bus model compiled first.
 */
`timescale 1ns/1ps
module tb_top;
    // ------------------------------------------------------------
    // signals
    // ------------------------------------------------------------
    localparam logic [12:0] E_SOF = 13'h0001, E_BOFF = 13'h0002,
        E_MSG = 13'h0004, E_ERR = 13'h0008, E_REQ0 = 13'h0080,
        E_OK0 = 13'h0200, E_OK1 = 13'h0400, E_ANY0 = 13'h0800,
        E_ANY1 = 13'h1000; // engine pulses by bit
    logic        clk, rst_n, we, cyc, ack, can_rx, tick, quiet;
    logic        busy, rx_role, tx_role, err_ie, wk_ie;
    logic        active, sshot, order, retry, fwr, fovr, irq;
    logic [3:0]  adr, err_en;
    logic [7:0]  dat, dat_o, q;
    logic [1:0]  pend;
    logic [12:0] ev;
    int          n_errors;
    int          checks;
    cms_can_mode_status uut (
        .REF_CLK(clk), .RESETN(rst_n), .WB_ADR_I(adr), .WB_DAT_I(dat),
        .WB_DAT_O(dat_o), .WB_WE_I(we), .WB_SEL_I(1'b1), .WB_STB_I(cyc),
        .WB_CYC_I(cyc), .WB_ACK_O(ack), .CAN_RX(can_rx), .BIT_TICK(tick),
        .FRAME_BUSY(busy), .RX_ROLE(rx_role), .TX_ROLE(tx_role),
        .SOF_SEEN(ev[0]), .BUSOFF_ENTER(ev[1]), .MSG_STORED(ev[2]),
        .ERR_SET(ev[6:3]), .TX_REQUEST(ev[8:7]), .TX_DONE_OK(ev[10:9]),
        .TX_DONE_ANY(ev[12:11]), .ERR_IRQ_EN(err_en),
        .ERROR_IRQ_ENABLE(err_ie), .WAKEUP_IRQ_ENABLE(wk_ie),
        .CAN_ACTIVE(active), .SINGLE_SHOT_TX(sshot),
        .TX_ORDER_BY_REQUEST(order), .RETRY_ALLOWED(retry),
        .FIFO_WRITE(fwr), .FIFO_OVERWRITE(fovr),
        .RX_PENDING_COUNT(pend), .STATUS_IRQ(irq));
    cms_bus_model u_bus (.REF_CLK(clk), .RESETN(rst_n), .quiet(quiet),
        .can_rx(can_rx), .bit_tick(tick));
    initial clk = 1'b0;
    always #20 clk = ~clk;
    // ------------------------------------------------------------
    // tasks
    // ------------------------------------------------------------
    task automatic chk(input logic [7:0] seen, input logic [7:0] exp,
                       input string what);
        checks++;
        if (seen !== exp) begin
            n_errors++;
            $display("wrong value %s expected %h seen %h", what, exp, seen);
        end
    endtask : chk
    // one classic wishbone cycle, held until ack is sampled
    task automatic bus(input logic [3:0] a, input logic w,
                       input logic [7:0] d, output logic [7:0] r);
        int n;
        n = 0;
        @(posedge clk);
        cyc <= 1'b1;
        adr <= a;
        we  <= w;
        dat <= d;
        do begin
            @(posedge clk);
            n++;
        end while (ack !== 1'b1 && n < 50);
        r = dat_o;
        cyc <= 1'b0;
        we  <= 1'b0;
        if (n >= 50) n_errors++;
    endtask : bus
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        bus(a, 1'b1, d, q);
    endtask : wr
    task automatic rd(input logic [3:0] a, input logic [7:0] e,
                      input string what);
        bus(a, 1'b0, 8'h00, q);
        chk(q, e, what);
    endtask : rd
    task automatic pulse(input logic [12:0] v);
        @(posedge clk);
        ev <= v;
        @(posedge clk);
        ev <= '0;
    endtask : pulse
    // waits a bounded time for the mode output
    task automatic settle(input logic e, input int lim);
        while (active !== e && lim > 0) begin
            @(posedge clk);
            lim--;
        end
        chk({7'h00, active}, {7'h00, e}, "can_active");
    endtask : settle
    task automatic final_report();
        if (n_errors == 0 && checks > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask : final_report
    // ------------------------------------------------------------
    // tests
    // ------------------------------------------------------------
    initial begin
        repeat (30000) @(posedge clk);
        n_errors++;
        final_report();
    end
    initial begin
        {rst_n, we, cyc, quiet, busy, rx_role, tx_role, err_ie} = '0;
        {wk_ie, adr, err_en, dat, ev, n_errors, checks} = '0;
        repeat (20) @(posedge clk);
        rst_n <= 1'b1;
        rd(4'h0, 8'h02, "master_control_reg");
        rd(4'h4, 8'h02, "master_status_reg");
        rd(4'h8, 8'h00, "transmit_status_reg");
        rd(4'h2, 8'h00, "unmapped");
        wr(4'h0, 8'h7D);
        @(posedge clk);
        chk({5'h00, sshot, retry, order}, 8'h05, "policy");
        wr(4'h0, 8'h01);
        @(posedge clk);
        chk({5'h00, sshot, retry, order}, 8'h02, "policy");
        wr(4'h0, 8'h00);
        repeat (60) @(posedge clk);
        rd(4'h4, 8'h01, "master_status_reg");
        quiet <= 1'b1;
        settle(1'b1, 100);
        rd(4'h4, 8'h00, "master_status_reg");
        rx_role <= 1'b1;
        rd(4'h4, 8'h20, "rx_active_flag");
        {rx_role, tx_role} <= 2'b01;
        rd(4'h4, 8'h10, "tx_active_flag");
        tx_role <= 1'b0;
        repeat (4) pulse(E_MSG);
        @(posedge clk);
        chk({6'h00, pend}, 8'h03, "rx_pending_count");
        wr(4'hC, 8'h20); // no reception active, release at once
        rd(4'hC, 8'h02, "rx_pending_count");
        wr(4'h0, 8'h08);
        repeat (2) pulse(E_MSG);
        repeat (4) wr(4'hC, 8'h20);
        rd(4'hC, 8'h00, "rx_pending_count");
        pulse(E_OK0 | E_ANY0);
        rd(4'h8, 8'h11, "transmit_status_reg");
        pulse(E_ANY1);
        pulse(E_REQ0);
        wr(4'h8, 8'h00);
        rd(4'h8, 8'h03, "transmit_status_reg");
        pulse(E_OK1 | E_ANY1);
        wr(4'h8, 8'h01);
        rd(4'h8, 8'h22, "transmit_status_reg");
        wr(4'h8, 8'h02);
        rd(4'h8, 8'h00, "transmit_status_reg");
        pulse(E_ERR);
        rd(4'h4, 8'h00, "error_event_flag");
        err_en <= 4'h1;
        pulse(E_ERR);
        err_ie <= 1'b1;
        @(posedge clk);
        chk({7'h00, irq}, 8'h01, "status_irq");
        err_ie <= 1'b0;
        wr(4'h4, 8'h00);
        rd(4'h4, 8'h04, "error_event_flag");
        wr(4'h4, 8'h04);
        rd(4'h4, 8'h00, "error_event_flag");
        busy <= 1'b1;
        wr(4'h0, 8'h02);
        rd(4'h4, 8'h00, "sleep_ack");
        busy <= 1'b0;
        rd(4'h4, 8'h02, "sleep_ack");
        pulse(E_SOF);
        rd(4'h4, 8'h0A, "wakeup_flag");
        wk_ie <= 1'b1;
        @(posedge clk);
        chk({7'h00, irq}, 8'h01, "status_irq");
        wk_ie <= 1'b0;
        wr(4'h4, 8'h08);
        wr(4'h0, 8'h00);
        rd(4'h4, 8'h00, "sleep_ack");
        settle(1'b1, 100);
        wr(4'h0, 8'h22);
        rd(4'h4, 8'h02, "sleep_ack");
        pulse(E_SOF);
        rd(4'h0, 8'h20, "master_control_reg");
        rd(4'h4, 8'h08, "master_status_reg");
        wr(4'h0, 8'h40);
        settle(1'b1, 100);
        pulse(E_BOFF);
        repeat (2000) @(posedge clk);
        chk({7'h00, active}, 8'h00, "can_active");
        settle(1'b1, 1500);
        wr(4'h0, 8'h00);
        pulse(E_BOFF);
        repeat (3500) @(posedge clk);
        chk({7'h00, active}, 8'h00, "can_active");
        wr(4'h0, 8'h01);
        wr(4'h0, 8'h00);
        settle(1'b1, 100);
        final_report();
    end
endmodule : tb_top
bind cms_can_mode_status cms_sva u_sva (.REF_CLK(REF_CLK),
    .RESETN(RESETN), .WB_ADR_I(WB_ADR_I), .WB_DAT_I(WB_DAT_I),
    .WB_DAT_O(WB_DAT_O), .WB_WE_I(WB_WE_I), .WB_STB_I(WB_STB_I),
    .WB_CYC_I(WB_CYC_I), .WB_ACK_O(WB_ACK_O), .FRAME_BUSY(FRAME_BUSY),
    .BUSOFF_ENTER(BUSOFF_ENTER), .MSG_STORED(MSG_STORED),
    .CAN_ACTIVE(CAN_ACTIVE), .SINGLE_SHOT_TX(SINGLE_SHOT_TX),
    .TX_ORDER_BY_REQUEST(TX_ORDER_BY_REQUEST),
    .RETRY_ALLOWED(RETRY_ALLOWED), .FIFO_WRITE(FIFO_WRITE),
    .FIFO_OVERWRITE(FIFO_OVERWRITE), .RX_PENDING_COUNT(RX_PENDING_COUNT));
